// [core/qasp_spi_regs.sv]
`timescale 1ns/1ns
// Serial register port of a four-core converter, sampled on system clock
module qasp_spi_regs #(
   parameter int NUM_CH = qasp_pkg::MAX_CH,
   parameter logic [7:0] ID_TYPE = 8'h5C,    // Arbitrary value
   parameter logic [3:0] ID_BRANCH = 4'h3,   // Arbitrary value
   parameter logic [3:0] ID_VERSION = 4'h2   // Arbitrary value
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_spi_rst_n,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_mosi,
   input wire logic [qasp_pkg::DATA_W-1:0] i_global_status,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] i_chan_status,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   output logic [qasp_pkg::DATA_W-1:0] o_adc_control,
   output logic [qasp_pkg::DATA_W-1:0] o_test_pattern,
   output logic [qasp_pkg::SYNC_W-1:0] o_sync_delay,
   output logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_cal_control,
   output logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_trim,
   output logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_offset_used,
   output logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_gain_used,
   output logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_phase_used,
   output logic [NUM_CH-1:0] o_cal_busy
);
   import qasp_pkg::*;

   // Bank select decodes two bits, so at most four channels
   if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
      $error("NUM_CH must be 1 to 4");
   end

   logic rst_n_s;
   logic cs_n_s;
   logic sclk_s;
   logic mosi_s;
   logic sclk_prev_q;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_rst;
   logic reg_rst;
   logic [4:0] bit_cnt_q;
   logic [FRAME_BITS-2:0] shift_q;
   logic [6:0] addr_q;
   logic is_wr_q;
   logic [DATA_W-1:0] wdata_q;
   logic wr_pend_q;
   logic [DATA_W-1:0] tx_q;
   logic commit;
   logic [6:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic swrst_q;
   logic [15:0] chsel_q;
   logic [1:0] bank;
   logic [NUM_CH-1:0] wr_ch;
   logic [NUM_CH*DATA_W-1:0] ext_ofs_all;
   logic [NUM_CH*DATA_W-1:0] ext_gain_all;
   logic [NUM_CH*DATA_W-1:0] ext_phs_all;

   // Pins come from outside: two flops before any logic
   qasp_sync #(
      .W(4),
      .RST_VAL(4'h4)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async({i_spi_rst_n, i_spi_cs_n, i_spi_sclk, i_spi_mosi}),
      .o_sync({rst_n_s, cs_n_s, sclk_s, mosi_s})
   );

   // Reset pin acts whatever the serial clock does
   assign frame_rst = i_rst | ~rst_n_s;
   assign reg_rst = frame_rst | swrst_q;

   // Serial clock edges found by the system clock
   always_ff @(posedge i_sys_clk) begin
      if (frame_rst) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_s;
      end
   end
   assign sclk_rise = sclk_s & ~sclk_prev_q;
   assign sclk_fall = ~sclk_s & sclk_prev_q;

   // Write lands only on a falling edge seen after deselect
   assign commit = sclk_fall & cs_n_s & wr_pend_q;
   assign rd_addr = {shift_q[5:0], mosi_s};
   assign bank = chsel_q[1:0];

   // Frame receive: address then data, MSB first
   always_ff @(posedge i_sys_clk) begin
      if (frame_rst) begin
         bit_cnt_q <= 5'h00;
         shift_q <= '0;
         addr_q <= 7'h00;
         is_wr_q <= 1'b0;
         wdata_q <= 16'h0000;
      end else if (cs_n_s) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise && bit_cnt_q != CNT_FULL) begin
         shift_q <= {shift_q[FRAME_BITS-3:0], mosi_s};
         bit_cnt_q <= bit_cnt_q + 5'h01;
         if (bit_cnt_q == CNT_ADDR_DONE) begin
            addr_q <= rd_addr;
            is_wr_q <= shift_q[6] == RW_WRITE;
         end
         if (bit_cnt_q == CNT_DATA_DONE) begin
            wdata_q <= {shift_q[14:0], mosi_s};
         end
      end
   end

   // Pending write: armed by the last data bit, taken by commit
   always_ff @(posedge i_sys_clk) begin
      if (frame_rst) begin
         wr_pend_q <= 1'b0;
      end else if (!cs_n_s && sclk_rise && bit_cnt_q == CNT_DATA_DONE) begin
         wr_pend_q <= is_wr_q;
      end else if (commit) begin
         wr_pend_q <= 1'b0;
      end else if (!cs_n_s && sclk_rise && bit_cnt_q == 5'h00) begin
         wr_pend_q <= 1'b0;  // Frame never closed; drop it
      end
   end

   // Read data out: bit 15 after the address, then one per rise
   always_ff @(posedge i_sys_clk) begin
      if (frame_rst) begin
         tx_q <= 16'h0000;
         o_spi_miso <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else if (cs_n_s) begin
         o_spi_miso <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else if (sclk_rise) begin
         if (bit_cnt_q == CNT_ADDR_DONE && shift_q[6] != RW_WRITE) begin
            tx_q <= rd_data;
            o_spi_miso <= rd_data[DATA_W-1];
            o_spi_miso_oe <= 1'b1;
         end else if (bit_cnt_q > CNT_ADDR_DONE &&
                      bit_cnt_q <= CNT_LAST_OUT) begin
            tx_q <= {tx_q[DATA_W-2:0], 1'b0};
            o_spi_miso <= tx_q[DATA_W-2];
         end
      end
   end

   // Soft reset pulse lasts one cycle, then reset clears it
   always_ff @(posedge i_sys_clk) begin
      if (reg_rst) begin
         swrst_q <= 1'b0;
      end else if (commit && addr_q == ADR_SWRST) begin
         swrst_q <= wdata_q[SWRST_BIT];
      end
   end

   // Common writable registers
   always_ff @(posedge i_sys_clk) begin
      if (reg_rst) begin
         o_adc_control <= RST_CTRL;
         o_test_pattern <= RST_TEST;
         o_sync_delay <= RST_SYNC;
         chsel_q <= RST_CHSEL;
      end else if (commit) begin
         case (addr_q)
            ADR_CTRL: begin
               o_adc_control <= wdata_q;
            end
            ADR_TEST: begin
               o_test_pattern <= wdata_q;
            end
            ADR_SYNC: begin
               o_sync_delay <= wdata_q[SYNC_W-1:0];
            end
            ADR_CHSEL: begin
               chsel_q <= wdata_q;
            end
            default: begin
               // Identity and read-only words ignore writes
            end
         endcase
      end
   end

   // Per-channel bank registers and calibration runs
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [DATA_W-1:0] calctl_q;
      logic [DATA_W-1:0] trim_q;
      logic [DATA_W-1:0] ext_ofs_q;
      logic [DATA_W-1:0] ext_gain_q;
      logic [DATA_W-1:0] ext_phs_q;
      logic [DATA_W-1:0] ofs_q;
      logic [DATA_W-1:0] gain_q;
      logic [DATA_W-1:0] phs_q;
      logic [7:0] cal_cnt_q;
      logic busy_q;
      logic cal_start;

      assign wr_ch[c] = commit && bank == 2'(c);
      assign cal_start = wr_ch[c] && addr_q == ADR_CALCTL &&
                         wdata_q[CAL_START_BIT];

      // Writable bank words
      always_ff @(posedge i_sys_clk) begin
         if (reg_rst) begin
            calctl_q <= RST_CALCTL;
            trim_q <= RST_TRIM;
            ext_ofs_q <= RST_ADJ;
            ext_gain_q <= RST_ADJ;
            ext_phs_q <= RST_ADJ;
         end else if (wr_ch[c]) begin
            case (addr_q)
               ADR_CALCTL: begin
                  calctl_q <= wdata_q;
               end
               ADR_TRIM: begin
                  trim_q <= wdata_q;
               end
               ADR_EXT_OFS: begin
                  ext_ofs_q <= wdata_q;
               end
               ADR_EXT_GAIN: begin
                  ext_gain_q <= wdata_q;
               end
               ADR_EXT_PHS: begin
                  ext_phs_q <= wdata_q;
               end
               default: begin
                  // Read-only bank words ignore writes
               end
            endcase
         end
      end

      // Run: busy for a fixed count, then load the used settings
      always_ff @(posedge i_sys_clk) begin
         if (reg_rst) begin
            cal_cnt_q <= 8'h00;
            busy_q <= 1'b0;
            ofs_q <= RST_ADJ;
            gain_q <= RST_ADJ;
            phs_q <= RST_ADJ;
         end else if (cal_start && !busy_q) begin
            cal_cnt_q <= CAL_BUSY_CYCLES;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            cal_cnt_q <= cal_cnt_q - 8'h01;
            if (cal_cnt_q == 8'h01) begin
               busy_q <= 1'b0;
               ofs_q <= ext_ofs_q;
               gain_q <= ext_gain_q;
               phs_q <= ext_phs_q;
            end
         end
      end

      assign o_cal_control[c*DATA_W +: DATA_W] = calctl_q;
      assign o_trim[c*DATA_W +: DATA_W] = trim_q;
      assign o_offset_used[c*DATA_W +: DATA_W] = ofs_q;
      assign o_gain_used[c*DATA_W +: DATA_W] = gain_q;
      assign o_phase_used[c*DATA_W +: DATA_W] = phs_q;
      assign o_cal_busy[c] = busy_q;
      assign ext_ofs_all[c*DATA_W +: DATA_W] = ext_ofs_q;
      assign ext_gain_all[c*DATA_W +: DATA_W] = ext_gain_q;
      assign ext_phs_all[c*DATA_W +: DATA_W] = ext_phs_q;
   end

   // Read mux; unmapped addresses and absent banks read zero
   always_comb begin
      rd_data = 16'h0000;
      case (rd_addr)
         ADR_ID: begin
            rd_data = {ID_TYPE, ID_BRANCH, ID_VERSION};
         end
         ADR_CTRL: begin
            rd_data = o_adc_control;
         end
         ADR_STAT: begin
            rd_data = i_global_status;
         end
         ADR_SWRST: begin
            rd_data = {15'h0000, swrst_q};
         end
         ADR_TEST: begin
            rd_data = o_test_pattern;
         end
         ADR_SYNC: begin
            rd_data = {12'h000, o_sync_delay};
         end
         ADR_CHSEL: begin
            rd_data = chsel_q;
         end
         default: begin
            rd_data = 16'h0000;
         end
      endcase
      if (int'(bank) < NUM_CH) begin
         case (rd_addr)
            ADR_CALCTL: begin
               rd_data = o_cal_control[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_CALBSY: begin
               rd_data = {15'h0000, o_cal_busy[bank]};
            end
            ADR_CHSTAT: begin
               rd_data = i_chan_status[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_TRIM: begin
               rd_data = o_trim[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_EXT_OFS: begin
               rd_data = ext_ofs_all[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_OFS: begin
               rd_data = o_offset_used[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_EXT_GAIN: begin
               rd_data = ext_gain_all[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_GAIN: begin
               rd_data = o_gain_used[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_EXT_PHS: begin
               rd_data = ext_phs_all[int'(bank)*DATA_W +: DATA_W];
            end
            ADR_PHS: begin
               rd_data = o_phase_used[int'(bank)*DATA_W +: DATA_W];
            end
            default: begin
            end
         endcase
      end
   end
endmodule

// [inc/qasp_pkg.sv]
// What this block does
// - Eight-bit address word first, MSB first
// - First bit: 0 reads, 1 writes
// - Reset pin resets interface and registers
// - Soft reset bit resets registers, not the interface
// - Both resets restore register defaults
// - All register words sixteen bits, whole-register access
// - Identity: type, branch, version fields
// - Control register fields, all-zero default
// - Sync delay register, four bits, default zero
// - Channel select picks per-channel bank
// - Per-channel calibration control and status
// - Per-channel busy flag for calibration polling
// - Per-channel impedance trim, resets to seven
// - External offset, gain, phase, default zero
// - Used offset/gain/phase follow calibration
// - Shift in and out on rising clock
// - Chip select active low gates shifting
// - Reset pin independent of serial clock
// - Sync delay covers zero to fifteen
package qasp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FRAME_BITS = 24;
   localparam int MAX_CH = 4;
   localparam int SYNC_W = 4;
   // Register addresses, seven bits below the direction flag
   localparam logic [6:0] ADR_ID = 7'h00;
   localparam logic [6:0] ADR_CTRL = 7'h01;
   localparam logic [6:0] ADR_STAT = 7'h02;
   localparam logic [6:0] ADR_SWRST = 7'h04;
   localparam logic [6:0] ADR_TEST = 7'h05;
   localparam logic [6:0] ADR_SYNC = 7'h06;
   localparam logic [6:0] ADR_CHSEL = 7'h0F;
   localparam logic [6:0] ADR_CALCTL = 7'h10;
   localparam logic [6:0] ADR_CALBSY = 7'h11;
   localparam logic [6:0] ADR_CHSTAT = 7'h12;
   localparam logic [6:0] ADR_TRIM = 7'h13;
   localparam logic [6:0] ADR_EXT_OFS = 7'h20;
   localparam logic [6:0] ADR_OFS = 7'h21;
   localparam logic [6:0] ADR_EXT_GAIN = 7'h22;
   localparam logic [6:0] ADR_GAIN = 7'h23;
   localparam logic [6:0] ADR_EXT_PHS = 7'h24;
   localparam logic [6:0] ADR_PHS = 7'h25;
   // Values after reset
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_TEST = 16'h0000;
   localparam logic [3:0] RST_SYNC = 4'h0;
   localparam logic [15:0] RST_CHSEL = 16'h0000;
   localparam logic [15:0] RST_CALCTL = 16'h0000;
   localparam logic [15:0] RST_TRIM = 16'h0007;
   localparam logic [15:0] RST_ADJ = 16'h0000;
   // Field positions
   localparam int SWRST_BIT = 0;
   localparam int CAL_START_BIT = 0;
   localparam int RW_BIT = 7;
   localparam logic RW_WRITE = 1'b1;
   // Frame bit counts at which phases end
   localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
   localparam logic [4:0] CNT_LAST_OUT = 5'h16;
   localparam logic [4:0] CNT_DATA_DONE = 5'h17;
   localparam logic [4:0] CNT_FULL = 5'h18;
   // Cycles a calibration run stays busy
   localparam logic [7:0] CAL_BUSY_CYCLES = 8'h20;
endpackage

// [core/qasp_sync.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for pins from outside the clock domain
module qasp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_q <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule

// [tb/qasp_spi_regs_props.sv]
`timescale 1ns/1ns
// Pin-level checks of the serial register port
module qasp_spi_regs_props
   import qasp_pkg::*;
#(
   parameter int NUM_CH = qasp_pkg::MAX_CH
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_spi_rst_n,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_sclk,
   input wire logic i_spi_mosi,
   input wire logic [qasp_pkg::DATA_W-1:0] i_global_status,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] i_chan_status,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe,
   input wire logic [qasp_pkg::DATA_W-1:0] o_adc_control,
   input wire logic [qasp_pkg::DATA_W-1:0] o_test_pattern,
   input wire logic [qasp_pkg::SYNC_W-1:0] o_sync_delay,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_cal_control,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_trim,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_offset_used,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_gain_used,
   input wire logic [NUM_CH*qasp_pkg::DATA_W-1:0] o_phase_used,
   input wire logic [NUM_CH-1:0] o_cal_busy
);
   logic at_dflt;
   logic [7:0] busy_len_q;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // Register outputs except used gain and phase at reset values, miso undriven
   assign at_dflt = o_adc_control == RST_CTRL && o_test_pattern == RST_TEST
      && o_sync_delay == RST_SYNC && o_trim == {NUM_CH{RST_TRIM}}
      && o_cal_control == '0 && o_offset_used == '0 && o_cal_busy == '0
      && !o_spi_miso_oe;
   // Length of the running busy spell on channel 0
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !o_cal_busy[0]) begin
         busy_len_q <= 8'h00;
      end else begin
         busy_len_q <= busy_len_q + 8'h01;
      end
   end
   a_rst_dflt: assert property ($fell(i_rst) |-> at_dflt)
      else $error("outputs not at defaults after reset");
   a_pin_rst_dflt: assert property (!i_spi_rst_n [*4] |=> at_dflt)
      else $error("reset pin did not restore defaults");
   a_cfg_on_idle: assert property (
      $changed(o_adc_control) || $changed(o_trim) |-> i_spi_cs_n)
      else $error("register changed inside a frame");
   a_miso_quiet: assert property (!o_spi_miso_oe |-> !o_spi_miso)
      else $error("miso not low while undriven");
   a_oe_deselect: assert property (i_spi_cs_n [*5] |=> !o_spi_miso_oe)
      else $error("miso driven while deselected");
   a_miso_on_rise: assert property (
      o_spi_miso_oe && $changed(o_spi_miso) |-> i_spi_sclk && !i_spi_cs_n)
      else $error("miso changed away from a clock rise");
   a_busy_len: assert property (
      $fell(o_cal_busy[0]) |-> busy_len_q == CAL_BUSY_CYCLES)
      else $error("calibration busy length wrong");
   a_used_on_cal: assert property (
      $changed(o_gain_used[DATA_W-1:0]) |-> $past(o_cal_busy[0])
      || $past(o_cal_busy[0], 2) || o_gain_used[DATA_W-1:0] == '0)
      else $error("used gain changed without calibration");
   // Main scenarios reached
   c_cal_done: cover property ($fell(o_cal_busy[0]));
   c_read_out: cover property ($rose(o_spi_miso_oe));
   c_pin_rst: cover property (!i_spi_rst_n ##1 i_spi_rst_n);
endmodule

// [tb/qasp_spi_master.sv]
`timescale 1ns/1ns
// Serial master model: idle-low clock, 8 address then 16 data bits
module qasp_spi_master (
   input wire logic i_sys_clk,
   input wire logic i_miso,
   input wire logic i_miso_oe,
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_mosi
);
   // Idle pins; the clock idles low, pulsing once after each deselect
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end
   // Four system clocks a phase, so a 400 ns serial period
   task automatic phase();
      repeat (4) @(posedge i_sys_clk);
   endtask
   // One whole frame; undriven miso reads back as unknown
   task automatic frame(input logic [7:0] a, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [23:0] sh;
      sh = {a, wd};
      rd = 16'h0000;
      @(posedge i_sys_clk);
      o_cs_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         phase();
         o_sclk <= 1'b0;
         o_mosi <= sh[i];
         phase();
         o_sclk <= 1'b1;
         if (i < 16) begin
            rd[i] = i_miso_oe ? i_miso : 1'bx;
         end
      end
      phase();
      o_sclk <= 1'b0;
      phase();
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi; // No stale bit left on the line
      phase();
      o_sclk <= 1'b1;
      phase();
      o_sclk <= 1'b0;
      phase();
   endtask
endmodule

// [tb/qasp_spi_regs_bench.sv]
`timescale 1ns/1ns
// Register port driven through the master model, answers checked
module qasp_spi_regs_bench;
   import qasp_pkg::*;
   typedef struct packed {
      logic [6:0] adr;
      logic wr;
      logic [15:0] wd;
      logic [15:0] exp;
   } qasp_row_s;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic rst_n = 1'b1;
   logic cs_n, sclk, mosi, miso, miso_oe;
   logic [15:0] gstat = 16'hBEEF;
   logic [63:0] cstat = 64'h4444_3333_2222_1111;
   logic [15:0] adc_ctl, test_pat, rv;
   logic [3:0] sync_dly, busy;
   logic [63:0] cal_ctl, trim, ofs_used, gain_used, phs_used;
   int error_cnt = 0;
   int comparisons = 0;
   qasp_row_s rows [17] = '{
      '{ADR_ID, 1'b0, 16'h0000, 16'h5C32},
      '{ADR_CTRL, 1'b0, 16'h0000, 16'h0000},
      '{ADR_SYNC, 1'b0, 16'h0000, 16'h0000},
      '{ADR_CHSEL, 1'b0, 16'h0000, 16'h0000},
      '{ADR_TRIM, 1'b0, 16'h0000, 16'h0007},
      '{ADR_CALBSY, 1'b0, 16'h0000, 16'h0000},
      '{ADR_STAT, 1'b0, 16'h0000, 16'hBEEF},
      '{ADR_ID, 1'b1, 16'hFFFF, 16'h5C32},
      '{ADR_CTRL, 1'b1, 16'hA5C3, 16'hA5C3},
      '{ADR_SYNC, 1'b1, 16'hFFFF, 16'h000F},
      '{ADR_TRIM, 1'b1, 16'h0019, 16'h0019},
      '{ADR_EXT_OFS, 1'b1, 16'h1111, 16'h1111},
      '{ADR_EXT_GAIN, 1'b1, 16'h2222, 16'h2222},
      '{ADR_TEST, 1'b1, 16'h1234, 16'h1234},
      '{ADR_CALCTL, 1'b1, 16'h00A0, 16'h00A0},
      '{ADR_OFS, 1'b1, 16'hFFFF, 16'h0000},
      '{7'h30, 1'b1, 16'h55AA, 16'h0000}
   };
   qasp_spi_regs uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_spi_rst_n(rst_n),
      .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
      .i_global_status(gstat), .i_chan_status(cstat), .o_spi_miso(miso),
      .o_spi_miso_oe(miso_oe), .o_adc_control(adc_ctl),
      .o_test_pattern(test_pat), .o_sync_delay(sync_dly),
      .o_cal_control(cal_ctl), .o_trim(trim), .o_offset_used(ofs_used),
      .o_gain_used(gain_used), .o_phase_used(phs_used), .o_cal_busy(busy));
   qasp_spi_master m (.i_sys_clk(sys_clk), .i_miso(miso),
      .i_miso_oe(miso_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
   // 20 MHz system clock
   always #25 sys_clk = ~sys_clk;
   task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] ign;
      m.frame({RW_WRITE, a}, d, ign);
   endtask
   task automatic reg_rd(input logic [6:0] a, output logic [15:0] d);
      m.frame({~RW_WRITE, a}, 16'h0000, d);
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Cuts a hang short; the run needs about 9200 cycles
   initial begin
      repeat (30000) @(posedge sys_clk);
      error_cnt++;
      report_and_stop();
   end
   // Table first, then banking, calibration and both resets
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      foreach (rows[i]) begin
         if (rows[i].wr) reg_wr(rows[i].adr, rows[i].wd);
         reg_rd(rows[i].adr, rv);
         chk("table row", rows[i].exp, rv);
      end
      chk("ctrl out", 16'hA5C3, adc_ctl);
      chk("test out", 16'h1234, test_pat);
      chk("sync out", 16'h000F, {12'h000, sync_dly});
      chk("calctl out", 16'h00A0, cal_ctl[15:0]);
      $display("test table done");
      reg_wr(ADR_CHSEL, 16'h0001);
      reg_wr(ADR_TRIM, 16'h0011);
      reg_rd(ADR_TRIM, rv);
      chk("trim bank b", 16'h0011, rv);
      chk("trim out b", 16'h0011, trim[31:16]);
      reg_rd(ADR_CHSTAT, rv);
      chk("status b", 16'h2222, rv);
      reg_wr(ADR_CHSEL, 16'h0000);
      reg_rd(ADR_TRIM, rv);
      chk("trim bank a", 16'h0019, rv);
      $display("test bank done");
      reg_wr(ADR_EXT_PHS, 16'h3333);
      reg_wr(ADR_CALCTL, 16'h0001);
      chk("busy set", 16'h0001, {15'h0000, busy[0]});
      for (int n = 0; n < 40 && busy[0] !== 1'b0; n++) @(posedge sys_clk);
      chk("busy clear", 16'h0000, {15'h0000, busy[0]});
      reg_rd(ADR_OFS, rv);
      chk("offset used", 16'h1111, rv);
      chk("gain used", 16'h2222, gain_used[15:0]);
      chk("phase used", 16'h3333, phs_used[15:0]);
      chk("offset out", 16'h1111, ofs_used[15:0]);
      reg_rd(ADR_PHS, rv);
      chk("phase read", 16'h3333, rv);
      $display("test calibration done");
      // Non-default bank select shows whether soft reset reaches it
      reg_wr(ADR_CHSEL, 16'h0002);
      reg_wr(ADR_SWRST, 16'h0001);
      reg_rd(ADR_CHSEL, rv);
      chk("chsel soft", 16'h0000, rv);
      chk("gain soft", 16'h0000, gain_used[15:0]);
      chk("test soft", 16'h0000, test_pat);
      reg_rd(ADR_CTRL, rv);
      chk("ctrl soft", 16'h0000, rv);
      reg_rd(ADR_SWRST, rv);
      chk("soft bit", 16'h0000, rv);
      chk("trim soft", 16'h0007, trim[15:0]);
      $display("test soft reset done");
      reg_wr(ADR_CTRL, 16'h00FF);
      chk("ctrl set", 16'h00FF, adc_ctl);
      rst_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("ctrl pin", 16'h0000, adc_ctl);
      chk("trim pin", 16'h0007, trim[63:48]);
      $display("test pin reset done");
      report_and_stop();
   end
endmodule
bind qasp_spi_regs qasp_spi_regs_props #(.NUM_CH(NUM_CH)) u_props (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_rst_n(i_spi_rst_n),
   .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk), .i_spi_mosi(i_spi_mosi),
   .i_global_status(i_global_status), .i_chan_status(i_chan_status),
   .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe),
   .o_adc_control(o_adc_control), .o_test_pattern(o_test_pattern),
   .o_sync_delay(o_sync_delay), .o_cal_control(o_cal_control),
   .o_trim(o_trim), .o_offset_used(o_offset_used),
   .o_gain_used(o_gain_used), .o_phase_used(o_phase_used),
   .o_cal_busy(o_cal_busy));
